// File: addr_map_pkg.sv
// Address map constants and types for the address space decoder.
// Assumes one system clock; every user writes addr_map_pkg::name.
`default_nettype none
package addr_map_pkg;

	// Memory regions (upper address byte)
	localparam logic [7:0]  REGION_DATA     = 8'h00;
	localparam logic [7:0]  REGION_EXT_LOW  = 8'h01;
	localparam logic [7:0]  REGION_EXT_HIGH = 8'hfe;
	localparam logic [7:0]  REGION_CODE     = 8'hff;

	// Offsets inside a region
	localparam logic [15:0] BANK_TOP        = 16'h001f;
	localparam logic [15:0] RAM_BASE        = 16'h0020;
	localparam logic [15:0] RAM_TOP         = 16'h041f;
	localparam logic [15:0] WINDOW_BASE     = 16'he000;
	localparam logic [15:0] ROM_TOP         = 16'h3fff;

	// Register file locations
	localparam logic [5:0]  RF_BANKED_TOP   = 6'h07;
	localparam logic [5:0]  RF_LOC_B        = 6'h0a;
	localparam logic [5:0]  RF_LOC_ACC      = 6'h0b;
	localparam logic [5:0]  RF_LOC_RSEL     = 6'h39;
	localparam logic [5:0]  RF_LOC_PTR_HIGH = 6'h3a;
	localparam logic [5:0]  RF_LOC_PTR_LOW  = 6'h3b;
	localparam logic [5:0]  RF_LOC_SP_HIGH  = 6'h3e;
	localparam logic [5:0]  RF_LOC_SP       = 6'h3f;

	// Special register addresses
	localparam logic [8:0]  SFR_RSEL        = 9'h084;
	localparam logic [8:0]  SFR_ACC         = 9'h0e0;
	localparam logic [8:0]  SFR_B           = 9'h0f0;
	localparam logic [8:0]  SFR_PTR_LOW     = 9'h082;
	localparam logic [8:0]  SFR_PTR_HIGH    = 9'h083;
	localparam logic [8:0]  SFR_SP          = 9'h081;
	localparam logic [8:0]  SFR_SP_HIGH     = 9'h0be;

	// Reset value and strap settling
	localparam logic [7:0]  RSEL_RESET      = 8'h01;
	localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

	typedef enum logic [2:0] {
		KIND_MEM, KIND_SFR, KIND_RF, KIND_LEG_CODE,
		KIND_LEG_XDATA, KIND_LEG_DIRECT, KIND_LEG_INDIRECT
	} kind_t;

	typedef enum logic [2:0] {
		TGT_RAM, TGT_ROM, TGT_EXT, TGT_SFR,
		TGT_RF, TGT_LOCAL, TGT_RESERVED, TGT_BLOCKED
	} target_t;

endpackage
`default_nettype wire

// File: address_space_decoder.sv
// Resolves CPU accesses into memory, special-register and register-file spaces.
// Assumes the requester is on the system clock; only the strap pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none

module address_space_decoder (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_i,
	input  wire logic                  external_access_strap_i,
	input  wire logic                  code_window_disable_i,
	input  wire logic                  bank_select_upper_i,
	input  wire logic                  bank_select_lower_i,
	input  wire logic                  req_valid_i,
	input  wire addr_map_pkg::kind_t   req_kind_i,
	input  wire logic [23:0]           req_addr_i,
	input  wire logic                  req_write_i,
	input  wire logic                  req_fetch_i,
	input  wire logic [7:0]            req_wdata_i,
	output var  logic                  resp_valid_o,
	output var  addr_map_pkg::target_t target_o,
	output var  logic [23:0]           target_addr_o,
	output var  logic                  write_en_o,
	output var  logic [7:0]            write_data_o,
	output var  logic [7:0]            local_rdata_o,
	output var  logic [7:0]            region_select_o,
	output var  logic                  strap_o,
	output var  logic                  strap_ready_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture and region classifier

	decode_if dec_bus ();

	strap_capture u_strap (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.strap_pin_i (external_access_strap_i),
		.strap_o     (strap_o),
		.ready_o     (strap_ready_o)
	);

	region_classify u_classify (
		.dec (dec_bus)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Space resolution

	logic                  mem_path;
	logic                  sfr_path;
	logic                  rf_path;
	logic [23:0]           mem_addr;
	logic [8:0]            sfr_addr;
	logic [5:0]            rf_loc;
	logic [1:0]            bank_sel;
	logic                  hit_local;
	addr_map_pkg::target_t target_next;
	logic [23:0]           addr_next;

	assign bank_sel = {bank_select_upper_i, bank_select_lower_i};

	always_comb begin
		mem_path = 1'b0;
		sfr_path = 1'b0;
		rf_path  = 1'b0;
		mem_addr = 24'h000000;
		sfr_addr = 9'h000;
		rf_loc   = 6'h00;
		unique case (req_kind_i)
			addr_map_pkg::KIND_MEM: begin
				mem_path = 1'b1;
				mem_addr = req_addr_i;
			end
			addr_map_pkg::KIND_SFR: begin
				sfr_path = 1'b1;
				sfr_addr = req_addr_i[8:0];
			end
			addr_map_pkg::KIND_RF: begin
				rf_path = 1'b1;
				rf_loc  = req_addr_i[5:0];
			end
			addr_map_pkg::KIND_LEG_CODE: begin
				mem_path = 1'b1;
				mem_addr = {addr_map_pkg::REGION_CODE, req_addr_i[15:0]};
			end
			addr_map_pkg::KIND_LEG_XDATA: begin
				mem_path = 1'b1;
				mem_addr = {region_select_o, req_addr_i[15:0]};
			end
			addr_map_pkg::KIND_LEG_DIRECT: begin
				if (req_addr_i[7]) begin
					sfr_path = 1'b1;
					sfr_addr = {1'b0, req_addr_i[7:0]};
				end else begin
					mem_path = 1'b1;
					mem_addr = {16'h0000, req_addr_i[7:0]};
				end
			end
			addr_map_pkg::KIND_LEG_INDIRECT: begin
				mem_path = 1'b1;
				mem_addr = {16'h0000, req_addr_i[7:0]};
			end
		endcase

		if (sfr_path) begin
			unique case (sfr_addr)
				addr_map_pkg::SFR_ACC: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_ACC;
				end
				addr_map_pkg::SFR_B: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_B;
				end
				addr_map_pkg::SFR_PTR_LOW: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_PTR_LOW;
				end
				addr_map_pkg::SFR_PTR_HIGH: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_PTR_HIGH;
				end
				addr_map_pkg::SFR_SP: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_SP;
				end
				addr_map_pkg::SFR_SP_HIGH: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_SP_HIGH;
				end
				addr_map_pkg::SFR_RSEL: begin
					rf_path = 1'b1;
					rf_loc  = addr_map_pkg::RF_LOC_RSEL;
				end
				default: begin
					rf_path = 1'b0;
				end
			endcase
			if (rf_path) begin
				sfr_path = 1'b0;
			end
		end

		if (rf_path && rf_loc <= addr_map_pkg::RF_BANKED_TOP) begin
			rf_path  = 1'b0;
			mem_path = 1'b1;
			mem_addr = {16'h0000, 3'h0, bank_sel, rf_loc[2:0]};
		end
	end

	assign dec_bus.addr       = mem_addr;
	assign dec_bus.is_fetch   = req_fetch_i && mem_path;
	assign dec_bus.is_write   = req_write_i;
	assign dec_bus.strap      = strap_o;
	assign dec_bus.window_dis = code_window_disable_i;

	assign hit_local = rf_path && rf_loc == addr_map_pkg::RF_LOC_RSEL;

	always_comb begin
		if (hit_local) begin
			target_next = addr_map_pkg::TGT_LOCAL;
			addr_next   = {18'h00000, rf_loc};
		end else if (rf_path) begin
			target_next = addr_map_pkg::TGT_RF;
			addr_next   = {18'h00000, rf_loc};
		end else if (sfr_path) begin
			target_next = addr_map_pkg::TGT_SFR;
			addr_next   = {15'h0000, sfr_addr};
		end else begin
			target_next = dec_bus.target;
			addr_next   = dec_bus.offset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Region-select register

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			region_select_o <= addr_map_pkg::RSEL_RESET;
		end else if (req_valid_i && req_write_i && hit_local) begin
			region_select_o <= req_wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered answer

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			resp_valid_o  <= 1'b0;
			target_o      <= addr_map_pkg::TGT_RESERVED;
			target_addr_o <= 24'h000000;
			write_en_o    <= 1'b0;
			write_data_o  <= 8'h00;
			local_rdata_o <= 8'h00;
		end else begin
			resp_valid_o  <= req_valid_i;
			target_o      <= target_next;
			target_addr_o <= addr_next;
			write_en_o    <= req_valid_i && req_write_i
				&& target_next != addr_map_pkg::TGT_RESERVED
				&& target_next != addr_map_pkg::TGT_BLOCKED
				&& target_next != addr_map_pkg::TGT_ROM;
			write_data_o  <= req_wdata_i;
			local_rdata_o <= hit_local ? region_select_o : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	sequence s_rsel_write;
		req_valid_i && req_write_i && req_kind_i == addr_map_pkg::KIND_SFR
			&& req_addr_i[8:0] == 9'h084;
	endsequence

	sequence s_rsel_read;
		req_valid_i && !req_write_i && req_kind_i == addr_map_pkg::KIND_RF
			&& req_addr_i[5:0] == 6'h39;
	endsequence

	sequence s_window_read;
		req_valid_i && req_kind_i == addr_map_pkg::KIND_MEM && !req_write_i && !req_fetch_i
			&& req_addr_i[23:13] == 11'h007 && strap_o && !code_window_disable_i;
	endsequence

	a_rsel_shared: assert property (
		s_rsel_write ##1 s_rsel_read |=> local_rdata_o == $past(req_wdata_i, 2))
		else $error("region select not shared between names");

	a_rsel_reset: assert property (
		$past(rst_i) |-> region_select_o == 8'h01)
		else $error("region select reset value wrong");

	a_xdata_region: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_LEG_XDATA
			&& region_select_o != 8'hff && region_select_o != 8'h00
		|=> target_addr_o == {$past(region_select_o), $past(req_addr_i[15:0])})
		else $error("external data address not formed from region select");

	a_code_strap: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_LEG_CODE && !strap_o
		|=> target_o == addr_map_pkg::TGT_EXT && target_addr_o[23:16] == 8'hff)
		else $error("code access with strap low not external");

	a_reserved_nowrite: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_MEM
			&& req_addr_i[23:16] >= 8'h02 && req_addr_i[23:16] <= 8'hfd
		|=> target_o == addr_map_pkg::TGT_RESERVED && !write_en_o)
		else $error("reserved region access not suppressed");

	a_bank_map: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_RF && req_addr_i[5:3] == 3'h0
		|=> target_o == addr_map_pkg::TGT_RAM
			&& target_addr_o == {16'h0000, 3'h0, $past(bank_sel), $past(req_addr_i[2:0])})
		else $error("banked register not mapped to active bank");

	a_fetch_block: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_MEM && req_fetch_i
			&& req_addr_i[23:16] == 8'h00 && req_addr_i[15:0] <= 16'h041f
		|=> target_o == addr_map_pkg::TGT_BLOCKED ##0 !write_en_o)
		else $error("fetch from data RAM not blocked");

	a_window_read: assert property (
		s_window_read |=> target_o == addr_map_pkg::TGT_ROM
			&& target_addr_o[13] && target_addr_o[12:0] == $past(req_addr_i[12:0]))
		else $error("code window read not served on chip");

	a_direct_upper: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_LEG_DIRECT && req_addr_i[7]
		|=> target_o != addr_map_pkg::TGT_RAM && target_o != addr_map_pkg::TGT_EXT)
		else $error("direct upper access reached memory");

	a_strap_hold: assert property (
		strap_ready_o |=> strap_ready_o && $stable(strap_o))
		else $error("latched strap changed");

	a_rf_upper: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_RF && req_addr_i[5:3] != 3'h0
		|=> target_o == addr_map_pkg::TGT_RF || target_o == addr_map_pkg::TGT_LOCAL)
		else $error("upper register location reached memory");

	a_rsel_retarget: assert property (
		s_rsel_write |=> region_select_o == $past(req_wdata_i))
		else $error("region select write not taken");

	a_indirect_ram: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_LEG_INDIRECT && !req_fetch_i
		|=> target_o == addr_map_pkg::TGT_RAM
			&& target_addr_o == {16'h0000, $past(req_addr_i[7:0])})
		else $error("indirect internal access not sent to RAM");

	a_legacy_code: assert property (
		req_valid_i && req_kind_i == addr_map_pkg::KIND_LEG_CODE
		|=> (target_o == addr_map_pkg::TGT_ROM
			&& target_addr_o[15:0] == $past(req_addr_i[15:0]))
			|| (target_o == addr_map_pkg::TGT_EXT
			&& target_addr_o == {8'hff, $past(req_addr_i[15:0])}))
		else $error("legacy code access left region FF");

endmodule
`default_nettype wire

// File: cpu_seq_model.sv
// Behavioural model of the CPU instruction sequencer that issues requests.
// Assumes the bench calls its tasks at a falling edge of the system clock.
`timescale 1ns/1ps
`default_nettype none
module cpu_seq_model (
	input  wire logic                clk_sys_i,
	output var  logic                req_valid_o,
	output var  addr_map_pkg::kind_t req_kind_o,
	output var  logic [23:0]         req_addr_o,
	output var  logic                req_write_o,
	output var  logic                req_fetch_o,
	output var  logic [7:0]          req_wdata_o
);

	initial begin
		req_valid_o = 1'h0;
		req_kind_o  = addr_map_pkg::KIND_MEM;
		req_addr_o  = 24'h000000;
		req_write_o = 1'h0;
		req_fetch_o = 1'h0;
		req_wdata_o = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Holds one request over the rising edge that takes it
	task automatic issue(input addr_map_pkg::kind_t k, input logic [23:0] a, input logic w,
		input logic f, input logic [7:0] d);
		req_valid_o = 1'h1;
		req_kind_o  = k;
		req_addr_o  = a;
		req_write_o = w;
		req_fetch_o = f;
		req_wdata_o = d;
		@(negedge clk_sys_i);
	endtask

	// Released lines except kind and valid show the inverse of their last value; valid drops, kind holds
	task automatic release_bus();
		req_valid_o = 1'h0;
		req_addr_o  = ~req_addr_o;
		req_write_o = ~req_write_o;
		req_fetch_o = ~req_fetch_o;
		req_wdata_o = ~req_wdata_o;
	endtask

endmodule
`default_nettype wire

// File: decode_if.sv
// Carrier between the decoder top and its memory region classifier.
// Purely combinational signals; no clock inside.
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
	logic [23:0]           addr;
	logic                  is_fetch;
	logic                  is_write;
	logic                  strap;
	logic                  window_dis;
	addr_map_pkg::target_t target;
	logic [23:0]           offset;

	modport requester (output addr, output is_fetch, output is_write, output strap,
		output window_dis, input target, input offset);
	modport classifier (input addr, input is_fetch, input is_write, input strap,
		input window_dis, output target, output offset);
endinterface
`default_nettype wire

// File: region_classify.sv
// Classifies a linear 24-bit memory address into its on-chip or external target.
// Assumes the strap is already latched and the window bit is static.
`timescale 1ns/1ps
`default_nettype none
module region_classify (
	decode_if.classifier dec
);
	always_comb begin
		dec.target = addr_map_pkg::TGT_RESERVED;
		dec.offset = dec.addr;
		unique case (dec.addr[23:16])
			addr_map_pkg::REGION_DATA: begin
				if (dec.addr[15:0] <= addr_map_pkg::RAM_TOP) begin
					dec.target = dec.is_fetch ? addr_map_pkg::TGT_BLOCKED
						: addr_map_pkg::TGT_RAM;
				end else if (dec.addr[15:0] >= addr_map_pkg::WINDOW_BASE && !dec.window_dis
						&& dec.strap && !dec.is_fetch && !dec.is_write) begin
					dec.target = addr_map_pkg::TGT_ROM;
					dec.offset = {10'h000, 1'b1, dec.addr[12:0]};
				end else begin
					dec.target = addr_map_pkg::TGT_EXT;
				end
			end
			addr_map_pkg::REGION_CODE: begin
				if (dec.addr[15:0] <= addr_map_pkg::ROM_TOP && dec.strap) begin
					dec.target = addr_map_pkg::TGT_ROM;
					dec.offset = {10'h000, dec.addr[13:0]};
				end else begin
					dec.target = addr_map_pkg::TGT_EXT;
				end
			end
			addr_map_pkg::REGION_EXT_LOW, addr_map_pkg::REGION_EXT_HIGH: begin
				dec.target = addr_map_pkg::TGT_EXT;
			end
			default: begin
				dec.target = addr_map_pkg::TGT_RESERVED;
			end
		endcase
	end
endmodule
`default_nettype wire

// File: strap_capture.sv
// Synchronises the external access strap and latches it once after reset.
// Assumes the strap pin is asynchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	input  wire logic strap_pin_i,
	output var  logic strap_o,
	output var  logic ready_o
);
	logic       meta_reg;
	logic       sync_reg;
	logic [1:0] settle_reg;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= strap_pin_i;
			sync_reg <= meta_reg;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			settle_reg <= 2'h0;
			strap_o    <= 1'b0;
			ready_o    <= 1'b0;
		end else if (!ready_o) begin
			if (settle_reg == addr_map_pkg::STRAP_SETTLE) begin
				strap_o <= sync_reg;
				ready_o <= 1'b1;
			end else begin
				settle_reg <= settle_reg + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb_address_space_decoder.sv
// Self-checking bench for the address space decoder.
// Assumes the sequencer model drives requests at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_address_space_decoder;

	localparam addr_map_pkg::kind_t   K_MEM = addr_map_pkg::KIND_MEM;
	localparam addr_map_pkg::kind_t   K_SFR = addr_map_pkg::KIND_SFR;
	localparam addr_map_pkg::kind_t   K_RF  = addr_map_pkg::KIND_RF;
	localparam addr_map_pkg::kind_t   K_LCD = addr_map_pkg::KIND_LEG_CODE;
	localparam addr_map_pkg::kind_t   K_LXD = addr_map_pkg::KIND_LEG_XDATA;
	localparam addr_map_pkg::kind_t   K_LDR = addr_map_pkg::KIND_LEG_DIRECT;
	localparam addr_map_pkg::kind_t   K_LIN = addr_map_pkg::KIND_LEG_INDIRECT;
	localparam addr_map_pkg::target_t T_RAM = addr_map_pkg::TGT_RAM;
	localparam addr_map_pkg::target_t T_ROM = addr_map_pkg::TGT_ROM;
	localparam addr_map_pkg::target_t T_EXT = addr_map_pkg::TGT_EXT;
	localparam addr_map_pkg::target_t T_SFR = addr_map_pkg::TGT_SFR;
	localparam addr_map_pkg::target_t T_RF  = addr_map_pkg::TGT_RF;
	localparam addr_map_pkg::target_t T_LOC = addr_map_pkg::TGT_LOCAL;
	localparam addr_map_pkg::target_t T_RES = addr_map_pkg::TGT_RESERVED;
	localparam addr_map_pkg::target_t T_BLK = addr_map_pkg::TGT_BLOCKED;
	localparam logic [1:0]            RD    = 2'h0;
	localparam logic [1:0]            WR    = 2'h1;
	localparam logic [1:0]            FE    = 2'h2;

	logic                  clk_sys_i;
	logic                  rst_i;
	logic                  external_access_strap_i;
	logic                  code_window_disable_i;
	logic                  bank_select_upper_i;
	logic                  bank_select_lower_i;
	logic                  req_valid;
	addr_map_pkg::kind_t   req_kind;
	logic [23:0]           req_addr;
	logic                  req_write;
	logic                  req_fetch;
	logic [7:0]            req_wdata;
	logic                  resp_valid_o;
	addr_map_pkg::target_t target_o;
	logic [23:0]           target_addr_o;
	logic                  write_en_o;
	logic [7:0]            write_data_o;
	logic [7:0]            local_rdata_o;
	logic [7:0]            region_select_o;
	logic                  strap_o;
	logic                  strap_ready_o;
	int                    num_errors;
	int                    samples_checked;
	int                    cycles;

	cpu_seq_model u_cpu (
		.clk_sys_i   (clk_sys_i),
		.req_valid_o (req_valid),
		.req_kind_o  (req_kind),
		.req_addr_o  (req_addr),
		.req_write_o (req_write),
		.req_fetch_o (req_fetch),
		.req_wdata_o (req_wdata)
	);

	address_space_decoder u_dut (
		.clk_sys_i               (clk_sys_i),
		.rst_i                   (rst_i),
		.external_access_strap_i (external_access_strap_i),
		.code_window_disable_i   (code_window_disable_i),
		.bank_select_upper_i     (bank_select_upper_i),
		.bank_select_lower_i     (bank_select_lower_i),
		.req_valid_i             (req_valid),
		.req_kind_i              (req_kind),
		.req_addr_i              (req_addr),
		.req_write_i             (req_write),
		.req_fetch_i             (req_fetch),
		.req_wdata_i             (req_wdata),
		.resp_valid_o            (resp_valid_o),
		.target_o                (target_o),
		.target_addr_o           (target_addr_o),
		.write_en_o              (write_en_o),
		.write_data_o            (write_data_o),
		.local_rdata_o           (local_rdata_o),
		.region_select_o         (region_select_o),
		.strap_o                 (strap_o),
		.strap_ready_o           (strap_ready_o)
	);

	initial begin
		clk_sys_i = 1'h0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t run did not finish", $time);
			stop_test();
		end
	end

	task automatic cmp_bit(input logic g, input logic e, input string m);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask

	task automatic cmp_val(input logic [23:0] g, input logic [23:0] e, input string m);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic cmp_tgt(input addr_map_pkg::target_t g, input addr_map_pkg::target_t e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t target got %s exp %s", $time, g.name(), e.name());
		end
	endtask

	// One request and its answer one edge later
	task automatic ac(input addr_map_pkg::kind_t k, input logic [1:0] op, input logic [23:0] a,
		input logic [7:0] d, input addr_map_pkg::target_t et, input logic [23:0] ea);
		logic ew;
		ew = (op == WR) && !(et inside {T_RES, T_BLK, T_ROM});
		u_cpu.issue(k, a, op[0], op[1], d);
		cmp_bit(resp_valid_o, 1'h1, "response strobe");
		cmp_tgt(target_o, et);
		if (et !== T_BLK) begin
			cmp_val(target_addr_o, ea, "target address");
		end
		cmp_bit(write_en_o, ew, "write enable");
		if (op == WR) begin
			cmp_val({16'h0000, write_data_o}, {16'h0000, d}, "write data");
		end
	endtask

	task automatic do_reset(input logic s);
		rst_i = 1'h1;
		external_access_strap_i = s;
		repeat (20) @(negedge clk_sys_i);
		cmp_bit(resp_valid_o, 1'h0, "strobe in reset");
		cmp_val({16'h0000, region_select_o}, 24'h000001, "select reset");
		rst_i = 1'h0;
		repeat (4) @(negedge clk_sys_i);
		cmp_bit(strap_ready_o, 1'h1, "strap ready");
		cmp_bit(strap_o, s, "strap latch");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		num_errors = 0;
		samples_checked = 0;
		cycles = 0;
		code_window_disable_i = 1'h0;
		bank_select_upper_i = 1'h0;
		bank_select_lower_i = 1'h0;
		do_reset(1'h1);
		// Region select and legacy external data
		ac(K_LXD, RD, 24'h001234, 8'h00, T_EXT, 24'h011234);
		ac(K_SFR, WR, 24'h000084, 8'h02, T_LOC, 24'h000039);
		ac(K_RF, RD, 24'h000039, 8'h00, T_LOC, 24'h000039);
		cmp_val({16'h0000, local_rdata_o}, 24'h000002, "select read");
		ac(K_LXD, RD, 24'h00beef, 8'h00, T_RES, 24'h02beef);
		ac(K_LDR, RD, 24'h000084, 8'h00, T_LOC, 24'h000039);
		cmp_val({16'h0000, local_rdata_o}, 24'h000002, "select alias");
		ac(K_RF, WR, 24'h000039, 8'h05, T_LOC, 24'h000039);
		ac(K_LXD, WR, 24'h000100, 8'haa, T_RES, 24'h050100);
		ac(K_MEM, RD, 24'h7f0000, 8'h00, T_RES, 24'h7f0000);
		cmp_val({16'h0000, local_rdata_o}, 24'h000000, "reserved read");
		ac(K_SFR, WR, 24'h000084, 8'hff, T_LOC, 24'h000039);
		ac(K_LXD, RD, 24'h005000, 8'h00, T_EXT, 24'hff5000);
		ac(K_LXD, RD, 24'h000100, 8'h00, T_ROM, 24'h000100);
		ac(K_SFR, WR, 24'h000084, 8'h01, T_LOC, 24'h000039);
		// Register file and bank selection
		for (int b = 0; b < 4; b++) begin
			bank_select_upper_i = b[1];
			bank_select_lower_i = b[0];
			ac(K_RF, RD, 24'h000003, 8'h00, T_RAM, {19'h00000, b[1:0], 3'h3});
		end
		ac(K_RF, RD, 24'h000008, 8'h00, T_RF, 24'h000008);
		ac(K_RF, RD, 24'h00003f, 8'h00, T_RF, 24'h00003f);
		// Special registers and legacy internal data
		ac(K_SFR, RD, 24'h000100, 8'h00, T_SFR, 24'h000100);
		ac(K_SFR, RD, 24'h0001ff, 8'h00, T_SFR, 24'h0001ff);
		ac(K_SFR, RD, 24'h0000e0, 8'h00, T_RF, 24'h00000b);
		ac(K_SFR, RD, 24'h0000f0, 8'h00, T_RF, 24'h00000a);
		ac(K_LDR, RD, 24'h000090, 8'h00, T_SFR, 24'h000090);
		ac(K_LIN, RD, 24'h000090, 8'h00, T_RAM, 24'h000090);
		ac(K_LDR, RD, 24'h00007f, 8'h00, T_RAM, 24'h00007f);
		ac(K_LIN, RD, 24'h000000, 8'h00, T_RAM, 24'h000000);
		// Linear memory space
		ac(K_MEM, RD, 24'h00001f, 8'h00, T_RAM, 24'h00001f);
		ac(K_MEM, WR, 24'h000020, 8'h5a, T_RAM, 24'h000020);
		ac(K_MEM, RD, 24'h00041f, 8'h00, T_RAM, 24'h00041f);
		ac(K_MEM, RD, 24'h000420, 8'h00, T_EXT, 24'h000420);
		ac(K_MEM, FE, 24'h000020, 8'h00, T_BLK, 24'h000020);
		ac(K_MEM, FE, 24'h010000, 8'h00, T_EXT, 24'h010000);
		ac(K_MEM, FE, 24'hfe1234, 8'h00, T_EXT, 24'hfe1234);
		ac(K_MEM, FE, 24'hff0000, 8'h00, T_ROM, 24'h000000);
		ac(K_MEM, WR, 24'hff3fff, 8'h11, T_ROM, 24'h003fff);
		ac(K_MEM, FE, 24'hff4000, 8'h00, T_EXT, 24'hff4000);
		ac(K_MEM, WR, 24'h020000, 8'h33, T_RES, 24'h020000);
		ac(K_MEM, RD, 24'hfdffff, 8'h00, T_RES, 24'hfdffff);
		ac(K_LCD, RD, 24'h00ffff, 8'h00, T_EXT, 24'hffffff);
		ac(K_LCD, FE, 24'h000200, 8'h00, T_ROM, 24'h000200);
		ac(K_MEM, RD, 24'h00e000, 8'h00, T_ROM, 24'h002000);
		ac(K_MEM, RD, 24'h00ffff, 8'h00, T_ROM, 24'h003fff);
		ac(K_MEM, FE, 24'h00e000, 8'h00, T_EXT, 24'h00e000);
		ac(K_MEM, WR, 24'h00e000, 8'h44, T_EXT, 24'h00e000);
		code_window_disable_i = 1'h1;
		ac(K_MEM, RD, 24'h00e000, 8'h00, T_EXT, 24'h00e000);
		code_window_disable_i = 1'h0;
		ac(K_SFR, WR, 24'h000084, 8'h7e, T_LOC, 24'h000039);
		u_cpu.release_bus();
		@(negedge clk_sys_i);
		cmp_bit(resp_valid_o, 1'h0, "idle strobe");
		// Second reset with the strap low, then the pin raised
		do_reset(1'h0);
		external_access_strap_i = 1'h1;
		ac(K_MEM, FE, 24'hff0000, 8'h00, T_EXT, 24'hff0000);
		ac(K_LCD, FE, 24'h000000, 8'h00, T_EXT, 24'hff0000);
		ac(K_MEM, RD, 24'h00e000, 8'h00, T_EXT, 24'h00e000);
		ac(K_LXD, RD, 24'h000000, 8'h00, T_EXT, 24'h010000);
		cmp_bit(strap_o, 1'h0, "strap held");
		u_cpu.release_bus();
		@(negedge clk_sys_i);
		stop_test();
	end

endmodule
`default_nettype wire
